//--- core/stx_exec.sv
// Execution unit for nibble swap, zero skips, table reads and XOR ops
//
// Overview of operation
// - Swap memory nibbles into accumulator, no flags
// - Zero byte skip: dummy cycle, two cycles
// - Copy byte to accumulator, skip when zero
// - Selected bit zero skips with dummy cycle
// - Current-page table read: low to memory, high
// - Last-page table read: low to memory, high
// - XOR into accumulator, only zero flag changes
// - XOR into memory, only zero flag changes
// - XOR immediate into accumulator, zero flag only
`timescale 1ns/1ps
module stx_exec
   import stx_pkg::*;
#(
   parameter int ROM_AW = 14        // Program ROM address width
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   input  wire logic              exec_valid,     // Instruction issued this cycle
   input  wire stx_op_t           exec_op,        // Decoded operation
   input  wire logic [7:0]        mem_rdata,      // Operand byte read from data memory
   input  wire logic [7:0]        imm_data,       // Immediate byte from instruction word
   input  wire logic [2:0]        bit_sel,        // Bit index for the bit-test skip
   input  wire logic [ROM_AW-1:0] pc_cur,         // Address of the executing instruction
   input  wire logic [7:0]        table_pointer_reg, // Table pointer contents
   input  wire logic [15:0]       rom_rdata,      // ROM word, sampled in the same cycle that rom_rd is high
   output logic                   rom_rd,         // ROM table fetch request
   output logic [ROM_AW-1:0]      rom_addr,       // ROM table fetch address
   output logic                   mem_we,         // Data memory write strobe
   output logic [7:0]             mem_wdata,      // Data memory write data
   output logic [7:0]             acc,            // Accumulator
   output logic [7:0]             table_high_byte_reg, // High byte of last table read
   output logic [5:0]             flags,          // Status flags, see package positions
   output logic                   fetch_discard,  // Prefetched instruction is dropped
   output logic                   busy            // Second cycle in progress
);

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   // Pointer supplies the low eight address bits, so the ROM must be wider
   if (ROM_AW <= 8 || ROM_AW > 16) begin : g_bad_aw
      $error("stx_exec: ROM_AW must be 9 to 16");
   end

   // ==========================================================
   // State and registers
   // ==========================================================
   stx_state_t        state_ff;          // Sequencer state
   stx_state_t        nxt_state;         // Next sequencer state
   logic [7:0]        acc_ff;            // Accumulator
   logic [7:0]        nxt_acc;           // Next accumulator
   logic [7:0]        table_high_byte_reg_ff;           // Table high byte
   logic [5:0]        flags_ff;          // Status flags
   logic [5:0]        nxt_flags;         // Next flags
   logic              we_ff;             // Memory write strobe
   logic              nxt_we;            // Next write strobe
   logic [7:0]        wdata_ff;          // Memory write data
   logic [7:0]        nxt_wdata;         // Next write data
   logic              rd_ff;             // ROM fetch request
   logic [ROM_AW-1:0] raddr_ff;          // ROM fetch address

   // ==========================================================
   // Decode and datapath wires
   // ==========================================================
   wire idle        = (state_ff == STX_ST_IDLE);
   wire go          = exec_valid && idle;
   wire byte_zero   = (mem_rdata == 8'h00);
   wire bit_zero    = ~mem_rdata[bit_sel];
   // Skip conditions of the three skip forms
   wire take_skip   = go && (((exec_op == STX_OP_SKIP_ZERO) && byte_zero) ||
                             ((exec_op == STX_OP_COPY_SKIP) && byte_zero) ||
                             ((exec_op == STX_OP_BIT_SKIP)  && bit_zero));
   wire is_tbl      = go && ((exec_op == STX_OP_TBL_CURRENT) ||
                             (exec_op == STX_OP_TBL_LAST));
   wire [7:0] swap_val = {mem_rdata[3:0], mem_rdata[7:4]};
   wire [7:0] xor_mem  = acc_ff ^ mem_rdata;
   wire [7:0] xor_imm  = acc_ff ^ imm_data;
   // Page bits: executing PC for current page, all ones for last page
   wire [ROM_AW-9:0] page_cur  = pc_cur[ROM_AW-1:8];
   wire [ROM_AW-9:0] page_last = '1;
   wire [ROM_AW-1:0] tbl_addr  = (exec_op == STX_OP_TBL_LAST) ?
                                 {page_last, table_pointer_reg} :
                                 {page_cur, table_pointer_reg};

   // ==========================================================
   // Next-state and datapath selection
   // ==========================================================
   always_comb begin
      nxt_state = state_ff;
      nxt_acc   = acc_ff;
      nxt_flags = flags_ff;
      nxt_we    = 1'b0;
      nxt_wdata = wdata_ff;
      case (state_ff)
         STX_ST_IDLE: begin
            if (go) begin
               case (exec_op)
                  STX_OP_NIBBLE_SWAP: nxt_acc = swap_val;
                  STX_OP_COPY_SKIP:   nxt_acc = mem_rdata;
                  STX_OP_XOR_ACC: begin
                     nxt_acc = xor_mem;
                     nxt_flags[STX_FLAG_Z] = (xor_mem == 8'h00);
                  end
                  STX_OP_XOR_MEM: begin
                     nxt_we    = 1'b1;
                     nxt_wdata = xor_mem;
                     nxt_flags[STX_FLAG_Z] = (xor_mem == 8'h00);
                  end
                  STX_OP_XOR_IMM: begin
                     nxt_acc = xor_imm;
                     nxt_flags[STX_FLAG_Z] = (xor_imm == 8'h00);
                  end
                  default: begin
                     nxt_flags = flags_ff;
                  end
               endcase
               if (take_skip) begin
                  nxt_state = STX_ST_DUMMY;
               end else if (is_tbl) begin
                  nxt_state = STX_ST_TABLE;
               end
            end
         end
         STX_ST_TABLE: begin
            nxt_we    = 1'b1;
            nxt_wdata = rom_rdata[7:0];
            nxt_state = STX_ST_IDLE;
         end
         STX_ST_DUMMY: begin
            nxt_state = STX_ST_IDLE;
         end
         default: begin
            nxt_state = STX_ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Sequencer and accumulator registers
   // ==========================================================
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= STX_ST_IDLE;
         acc_ff   <= STX_ACC_RST;
         flags_ff <= STX_FLAGS_RST;
         we_ff    <= 1'b0;
         wdata_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         acc_ff   <= nxt_acc;
         flags_ff <= nxt_flags;
         we_ff    <= nxt_we;
         wdata_ff <= nxt_wdata;
      end
   end

   // ==========================================================
   // Table fetch and high byte register
   // ==========================================================
   // Address is registered so the ROM sees a clean value for a full cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_ff    <= 1'b0;
         raddr_ff <= '0;
         table_high_byte_reg_ff  <= STX_TABLE_HIGH_BYTE_REG_RST;
      end else begin
         rd_ff <= is_tbl;
         if (is_tbl) begin
            raddr_ff <= tbl_addr;
         end
         if (state_ff == STX_ST_TABLE) begin
            table_high_byte_reg_ff <= rom_rdata[15:8];
         end
      end
   end

   assign rom_rd              = rd_ff;
   assign rom_addr            = raddr_ff;
   assign mem_we              = we_ff;
   assign mem_wdata           = wdata_ff;
   assign acc                 = acc_ff;
   assign table_high_byte_reg = table_high_byte_reg_ff;
   assign flags               = flags_ff;
   assign fetch_discard       = (state_ff == STX_ST_DUMMY);
   assign busy                = !idle;

   // ==========================================================
   // Assertions
   // ==========================================================
   chk_skip_dummy_cycle: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      take_skip |=> fetch_discard ##1 !fetch_discard)
      else $error("skip did not take exactly one dummy cycle");

   chk_noskip_one_cycle: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (go && exec_op == STX_OP_BIT_SKIP && !bit_zero) |=> !busy)
      else $error("set bit must not skip");

   chk_swap_value: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (go && exec_op == STX_OP_NIBBLE_SWAP) |=>
      (acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}) && $stable(flags))
      else $error("nibble swap result wrong");

   chk_copy_skip_acc: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (go && exec_op == STX_OP_COPY_SKIP) |=> acc == $past(mem_rdata))
      else $error("copy skip did not load accumulator");

   chk_table_write: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      is_tbl |=> rom_rd ##1 (mem_we && mem_wdata == $past(rom_rdata[7:0])
      && table_high_byte_reg == $past(rom_rdata[15:8])))
      else $error("table read did not deliver both bytes");

   chk_last_page_addr: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (is_tbl && exec_op == STX_OP_TBL_LAST) |=>
      rom_addr == {{(ROM_AW-8){1'b1}}, $past(table_pointer_reg)})
      else $error("last page address wrong");

   chk_cur_page_addr: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (is_tbl && exec_op == STX_OP_TBL_CURRENT) |=>
      rom_addr == {$past(pc_cur[ROM_AW-1:8]), $past(table_pointer_reg)})
      else $error("current page address wrong");

   chk_xor_acc_zero: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (go && exec_op == STX_OP_XOR_ACC) |=> (acc == ($past(acc) ^ $past(mem_rdata)))
      && flags[STX_FLAG_Z] == (acc == 8'h00) && !mem_we)
      else $error("XOR to accumulator wrong");

   chk_xor_mem_write: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (go && exec_op == STX_OP_XOR_MEM) |=> mem_we && $stable(acc)
      && mem_wdata == ($past(acc) ^ $past(mem_rdata))
      && flags[STX_FLAG_Z] == (mem_wdata == 8'h00))
      else $error("XOR to memory wrong");

   chk_xor_imm_value: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (go && exec_op == STX_OP_XOR_IMM) |=> acc == ($past(acc) ^ $past(imm_data))
      && flags[STX_FLAG_Z] == (acc == 8'h00))
      else $error("XOR immediate wrong");

   chk_flags_kept: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      // Second cycle is only owned by this op while busy; otherwise a new op may issue
      (go && (exec_op == STX_OP_SKIP_ZERO || exec_op == STX_OP_BIT_SKIP ||
              exec_op == STX_OP_COPY_SKIP || exec_op == STX_OP_NIBBLE_SWAP || is_tbl))
      |=> $stable(flags) ##1 (!$past(busy) || $stable(flags)))
      else $error("flags changed by a flag-neutral op");

endmodule

//--- core/stx_pkg.sv
// Package for the skip, table-read and XOR execution unit
package stx_pkg;

   // ==========================================================
   // Operation select codes
   // ==========================================================
   typedef enum logic [3:0] {
      STX_OP_NONE          = 4'h0,
      STX_OP_NIBBLE_SWAP   = 4'h1,
      STX_OP_SKIP_ZERO     = 4'h2,
      STX_OP_COPY_SKIP     = 4'h3,
      STX_OP_BIT_SKIP      = 4'h4,
      STX_OP_TBL_CURRENT   = 4'h5,
      STX_OP_TBL_LAST      = 4'h6,
      STX_OP_XOR_ACC       = 4'h7,
      STX_OP_XOR_MEM       = 4'h8,
      STX_OP_XOR_IMM       = 4'h9
   } stx_op_t;

   // ==========================================================
   // Execute sequencer states, one-hot
   // ==========================================================
   typedef enum logic [2:0] {
      STX_ST_IDLE  = 3'b001,
      STX_ST_TABLE = 3'b010,
      STX_ST_DUMMY = 3'b100
   } stx_state_t;

   // ==========================================================
   // Reset values and flag field positions
   // ==========================================================
   localparam logic [7:0] STX_ACC_RST  = 8'h00;
   localparam logic [7:0] STX_TABLE_HIGH_BYTE_REG_RST = 8'h00;
   localparam int         STX_FLAG_C  = 0;
   localparam int         STX_FLAG_AC = 1;
   localparam int         STX_FLAG_Z  = 2;
   localparam int         STX_FLAG_OV = 3;
   localparam int         STX_FLAG_PD = 4;
   localparam int         STX_FLAG_TO = 5;
   localparam logic [5:0] STX_FLAGS_RST = 6'h00;

endpackage

//--- sim/tb.sv
// Self-checking bench for the skip, table-read and XOR execution unit
`timescale 1ns/1ps
module tb;
   import stx_pkg::*;
   // ==========================================================
   // Row of the ordinary case table: inputs, then expected outputs
   // ==========================================================
   typedef struct packed {
      stx_op_t    op;
      logic [7:0] mem, imm;
      logic [2:0] bs;
      logic [7:0] acc;
      logic [5:0] flg;
      logic       we;
      logic [7:0] wd;
      logic       disc;
   } stx_row_t;
   localparam stx_row_t ROWS [15] = '{
      '{STX_OP_XOR_IMM, 8'h00, 8'ha5, 3'h0, 8'ha5, 6'h00, 1'h0, 8'h00, 1'h0},
      '{STX_OP_XOR_ACC, 8'ha5, 8'h00, 3'h0, 8'h00, 6'h04, 1'h0, 8'h00, 1'h0},
      '{STX_OP_NIBBLE_SWAP, 8'h3c, 8'h00, 3'h0, 8'hc3, 6'h04, 1'h0, 8'h00, 1'h0},
      '{STX_OP_XOR_MEM, 8'hc3, 8'h00, 3'h0, 8'hc3, 6'h04, 1'h1, 8'h00, 1'h0},
      '{STX_OP_XOR_MEM, 8'h01, 8'h00, 3'h0, 8'hc3, 6'h00, 1'h1, 8'hc2, 1'h0},
      '{STX_OP_SKIP_ZERO, 8'h00, 8'h00, 3'h0, 8'hc3, 6'h00, 1'h0, 8'h00, 1'h1},
      '{STX_OP_SKIP_ZERO, 8'h80, 8'h00, 3'h0, 8'hc3, 6'h00, 1'h0, 8'h00, 1'h0},
      '{STX_OP_COPY_SKIP, 8'h00, 8'h00, 3'h0, 8'h00, 6'h00, 1'h0, 8'h00, 1'h1},
      '{STX_OP_COPY_SKIP, 8'h5a, 8'h00, 3'h0, 8'h5a, 6'h00, 1'h0, 8'h00, 1'h0},
      '{STX_OP_BIT_SKIP, 8'hf7, 8'h00, 3'h3, 8'h5a, 6'h00, 1'h0, 8'h00, 1'h1},
      '{STX_OP_BIT_SKIP, 8'h08, 8'h00, 3'h3, 8'h5a, 6'h00, 1'h0, 8'h00, 1'h0},
      '{STX_OP_XOR_IMM, 8'h00, 8'h5a, 3'h0, 8'h00, 6'h04, 1'h0, 8'h00, 1'h0},
      '{STX_OP_NIBBLE_SWAP, 8'h12, 8'h00, 3'h0, 8'h21, 6'h04, 1'h0, 8'h00, 1'h0},
      '{STX_OP_COPY_SKIP, 8'h00, 8'h00, 3'h0, 8'h00, 6'h04, 1'h0, 8'h00, 1'h1},
      '{STX_OP_XOR_ACC, 8'h20, 8'h00, 3'h0, 8'h20, 6'h00, 1'h0, 8'h00, 1'h0}
   };
   logic          clk_sys, rst_b, exec_valid, rom_rd, mem_we, fetch_discard, busy;
   stx_op_t       exec_op;
   logic [7:0]    mem_rdata, imm_data, table_pointer_reg, mem_wdata, acc;
   logic [7:0]    table_high_byte_reg;
   logic [2:0]    bit_sel;
   logic [13:0]   pc_cur, rom_addr;
   logic [15:0]   rom_rdata;
   logic [5:0]    flags;
   int            bad_count, checks_done;
   // Combinational ROM: every address bit shows in the word, so a wrong page is seen
   assign rom_rdata = {2'h0, rom_addr} ^ 16'h5a5a;
   stx_exec #(.ROM_AW(14)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .exec_valid(exec_valid),
      .exec_op(exec_op), .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel),
      .pc_cur(pc_cur), .table_pointer_reg(table_pointer_reg), .rom_rdata(rom_rdata),
      .rom_rd(rom_rd), .rom_addr(rom_addr), .mem_we(mem_we), .mem_wdata(mem_wdata),
      .acc(acc), .table_high_byte_reg(table_high_byte_reg), .flags(flags),
      .fetch_discard(fetch_discard), .busy(busy));
   // ==========================================================
   // Clock, watchdog and helpers
   // ==========================================================
   initial begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Cuts a hang short; the whole run needs far fewer cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      $display("mismatch watchdog expected finish seen hang");
      end_sim;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Drive an issue; caller sits on a falling edge
   task automatic issue(input stx_op_t op, input logic [7:0] m, i, input logic [2:0] b);
      exec_op = op;
      mem_rdata = m;
      imm_data = i;
      bit_sel = b;
      exec_valid = 1'h1;
   endtask
   // Table read with a refused issue held high during the busy cycle
   task automatic tbl(input stx_op_t op, input logic [13:0] pc, input logic [7:0] tp,
                      input logic [13:0] ea);
      logic [15:0] w;
      logic [7:0]  a0;
      w = {2'h0, ea} ^ 16'h5a5a;
      a0 = acc;
      pc_cur = pc;
      table_pointer_reg = tp;
      issue(op, 8'h00, 8'h00, 3'h0);
      @(negedge clk_sys);
      issue(STX_OP_XOR_IMM, 8'h00, 8'hff, 3'h0);
      chk("rom_rd", 1, rom_rd);
      chk("rom_addr", ea, rom_addr);
      chk("busy", 1, busy);
      @(negedge clk_sys);
      // Refused XOR stays on the pins; the caller issues over it at once
      chk("mem_we", 1, mem_we);
      chk("rom_rd end", 0, rom_rd);
      chk("busy end", 0, busy);
      chk("mem_wdata", w[7:0], mem_wdata);
      chk("table_high_byte_reg", w[15:8], table_high_byte_reg);
      chk("acc", a0, acc);
      chk("flags", 6'h00, flags);
      $display("table read test done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      bad_count = 0;
      checks_done = 0;
      rst_b = 1'h0;
      pc_cur = 14'h0000;
      table_pointer_reg = 8'h00;
      issue(STX_OP_NONE, 8'h00, 8'h00, 3'h0);
      exec_valid = 1'h0;
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("reset", 16'h0000, {acc, flags, mem_we, rom_rd});
      chk("reset table_high_byte_reg", 0, {table_high_byte_reg, fetch_discard, busy});
      $display("reset test done");
      rst_b = 1'h1;
      // Ordinary cases, one per row
      for (int i = 0; i < 15; i++) begin
         issue(ROWS[i].op, ROWS[i].mem, ROWS[i].imm, ROWS[i].bs);
         @(negedge clk_sys);
         chk("acc", ROWS[i].acc, acc);
         chk("flags", ROWS[i].flg, flags);
         chk("mem_we", ROWS[i].we, mem_we);
         if (ROWS[i].we) chk("mem_wdata", ROWS[i].wd, mem_wdata);
         chk("fetch_discard", ROWS[i].disc, fetch_discard);
         chk("busy", ROWS[i].disc, busy);
         // A taken skip needs its dummy cycle before the next issue
         if (ROWS[i].disc) begin
            exec_valid = 1'h0;
            @(negedge clk_sys);
         end
      end
      $display("row table test done");
      // Every bit index of the bit-test skip; odd bits of 0x55 are zero
      for (int b = 0; b < 8; b++) begin
         issue(STX_OP_BIT_SKIP, 8'h55, 8'h00, b[2:0]);
         @(negedge clk_sys);
         chk("bit skip", b[0], fetch_discard);
         chk("bit busy", b[0], busy);
         if (b[0]) begin
            exec_valid = 1'h0;
            @(negedge clk_sys);
         end
      end
      $display("bit index test done");
      tbl(STX_OP_TBL_CURRENT, 14'h2a10, 8'h77, 14'h2a77);
      tbl(STX_OP_TBL_LAST, 14'h0105, 8'hff, 14'h3fff);
      // Back-to-back XOR immediates, valid held over two edges
      issue(STX_OP_XOR_IMM, 8'h00, 8'h0f, 3'h0);
      @(negedge clk_sys);
      chk("acc b2b", 8'h2f, acc);
      imm_data = 8'h2f;
      @(negedge clk_sys);
      chk("acc b2b", 8'h00, acc);
      chk("flags b2b", 6'h04, flags);
      $display("back to back test done");
      // Reset in the middle of a taken skip
      issue(STX_OP_SKIP_ZERO, 8'h00, 8'h00, 3'h0);
      @(negedge clk_sys);
      exec_valid = 1'h0;
      rst_b = 1'h0;
      #1;
      chk("mid reset", 0, {acc, flags, fetch_discard, busy});
      @(negedge clk_sys);
      rst_b = 1'h1;
      issue(STX_OP_XOR_IMM, 8'h00, 8'h80, 3'h0);
      @(negedge clk_sys);
      exec_valid = 1'h0;
      chk("acc after reset", 8'h80, acc);
      $display("mid reset test done");
      end_sim;
   end
endmodule
